/* hw/pwmoi_cfg.svh */
`ifndef PWMOI_CFG_SVH
`define PWMOI_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PWMOI_OFS_INIT  8'h1C
`define PWMOI_OFS_MASK  8'h1D
`define PWMOI_OFS_SYNC  8'h20

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PWMOI_SYNC_SEL_BIT 0
`define PWMOI_RST_BYTE     8'h00
`define PWMOI_RST_BIT      1'b0
`define PWMOI_NCH          8

`endif

/* hw/pwmoi_pkg.sv */
`include "pwmoi_cfg.svh"

package pwmoi_pkg;

  // --------------------------------------------------------------------
  // Register port request
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pwmoi_req_s;

  // --------------------------------------------------------------------
  // Per-channel waveform from the compare logic
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [`PWMOI_NCH-1:0] level;
    logic [`PWMOI_NCH-1:0] match;
    logic [`PWMOI_NCH-1:0] idle_level;
  } pwmoi_wave_s;

  // --------------------------------------------------------------------
  // Mask transfer timing
  // --------------------------------------------------------------------
  typedef enum logic {
    PWMOI_XFER_EVERY_CLK = 1'b0,
    PWMOI_XFER_ON_SYNC   = 1'b1
  } pwmoi_xfer_e;

endpackage

/* hw/pwmoi_chan.sv */
`timescale 1ns/1ps
`include "pwmoi_cfg.svh"

module pwmoi_chan
  import pwmoi_pkg::*;
(
  // Clock and reset
  input  logic clock,
  input  logic rst,
  // Control
  input  logic init_pulse,
  input  logic init_value,
  input  logic mask_on,
  // Waveform
  input  logic idle_level,
  input  logic match,
  input  logic level,
  // Output
  output logic out_bit
);

  logic out_reg;

  // --------------------------------------------------------------------
  // Output flip-flop
  // --------------------------------------------------------------------
  // Init wins over mask so a forced start value is always visible
  always_ff @(posedge clock)
  begin
    if (rst)
      out_reg <= `PWMOI_RST_BIT;
    else if (init_pulse)
      out_reg <= init_value;
    else if (mask_on)
      out_reg <= idle_level;
    else if (match)
      out_reg <= level;
  end

  assign out_bit = out_reg;

endmodule

/* hw/pwmoi_mask_buf.sv */
`timescale 1ns/1ps
`include "pwmoi_cfg.svh"

module pwmoi_mask_buf
  import pwmoi_pkg::*;
(
  // Clock and reset
  input  logic                  clock,
  input  logic                  rst,
  // Buffer load
  input  logic                  load,
  input  logic [`PWMOI_NCH-1:0] load_value,
  // Transfer control
  input  pwmoi_xfer_e           xfer_mode,
  input  logic                  sync_event,
  // State
  output logic [`PWMOI_NCH-1:0] pending,
  output logic [`PWMOI_NCH-1:0] active
);

  logic [`PWMOI_NCH-1:0] buf_reg;
  logic [`PWMOI_NCH-1:0] act_reg;

  // --------------------------------------------------------------------
  // Write buffer
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      buf_reg <= `PWMOI_RST_BYTE;
    else if (load)
      buf_reg <= load_value;
  end

  // --------------------------------------------------------------------
  // Active mask
  // --------------------------------------------------------------------
  // A write and a sync in one cycle moves the old buffer content
  always_ff @(posedge clock)
  begin
    if (rst)
      act_reg <= `PWMOI_RST_BYTE;
    else if (xfer_mode == PWMOI_XFER_EVERY_CLK || sync_event)
      act_reg <= buf_reg;
  end

  assign pending = buf_reg;
  assign active  = act_reg;

endmodule

/* hw/pwmoi_top.sv */
// Behaviour
// - Eight init bits, bit n for channel n, zero after reset.
// - On output initialization each channel output takes its init bit.
// - Eight mask bits, bit n for channel n, zero after reset.
// - Active mask one holds the channel output at its inactive level, except on an init strobe, where the init bit wins.
// - Active mask zero passes the normal channel output through.
// - Masked channels ignore compare matches; unmasked ones follow them.
// - Mask writes load a write buffer only, not the active mask.
// - The buffer moves into the active mask at the sync point.
// - Select zero reloads every clock; select one only on sync event.
`timescale 1ns/1ps
`include "pwmoi_cfg.svh"

module pwmoi_top
  import pwmoi_pkg::*;
(
  // Clock and reset
  input  logic                  clock,
  input  logic                  rst,
  // Register port
  input  pwmoi_req_s            reg_req,
  output logic [7:0]            reg_rdata,
  // Timer events
  input  logic                  init_strobe,
  input  logic                  pwm_sync,
  // Waveform from compare logic
  input  pwmoi_wave_s           wave,
  // Channel outputs
  output logic [`PWMOI_NCH-1:0] chan_out
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [`PWMOI_NCH-1:0] output_init_reg;
  logic                  mask_sync_select_reg;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;
  logic [`PWMOI_NCH-1:0] mask_pending;
  logic [`PWMOI_NCH-1:0] output_mask_reg;
  logic                  wr_init;
  logic                  wr_mask;
  logic                  wr_sync;
  pwmoi_xfer_e           xfer_mode;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  assign wr_init = reg_req.wr && (reg_req.addr == `PWMOI_OFS_INIT);
  assign wr_mask = reg_req.wr && (reg_req.addr == `PWMOI_OFS_MASK);
  assign wr_sync = reg_req.wr && (reg_req.addr == `PWMOI_OFS_SYNC);

  assign xfer_mode = mask_sync_select_reg ? PWMOI_XFER_ON_SYNC
                                          : PWMOI_XFER_EVERY_CLK;

  // --------------------------------------------------------------------
  // Init value register
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      output_init_reg <= `PWMOI_RST_BYTE;
    else if (wr_init)
      output_init_reg <= reg_req.wdata;
  end

  // --------------------------------------------------------------------
  // Mask sync select
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      mask_sync_select_reg <= `PWMOI_RST_BIT;
    else if (wr_sync)
      mask_sync_select_reg <= reg_req.wdata[`PWMOI_SYNC_SEL_BIT];
  end

  // --------------------------------------------------------------------
  // Mask write buffer and active mask
  // --------------------------------------------------------------------
  pwmoi_mask_buf u_mask_buf
  (
    .clock      (clock),
    .rst        (rst),
    .load       (wr_mask),
    .load_value (reg_req.wdata),
    .xfer_mode  (xfer_mode),
    .sync_event (pwm_sync),
    .pending    (mask_pending),
    .active     (output_mask_reg)
  );

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Pending buffer stays hidden; software sees what drives the pins
  always_comb
  begin
    rdata_next = `PWMOI_RST_BYTE;
    case (reg_req.addr)
      `PWMOI_OFS_INIT: rdata_next = output_init_reg;
      `PWMOI_OFS_MASK: rdata_next = output_mask_reg;
      `PWMOI_OFS_SYNC: rdata_next[`PWMOI_SYNC_SEL_BIT] = mask_sync_select_reg;
      default:         rdata_next = `PWMOI_RST_BYTE;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_reg <= `PWMOI_RST_BYTE;
    else if (reg_req.rd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= `PWMOI_RST_BYTE;
  end

  assign reg_rdata = rdata_reg;

  // --------------------------------------------------------------------
  // Channel output stages
  // --------------------------------------------------------------------
  for (genvar i = 0; i < `PWMOI_NCH; i++)
  begin : g_chan
    pwmoi_chan u_chan
    (
      .clock      (clock),
      .rst        (rst),
      .init_pulse (init_strobe),
      .init_value (output_init_reg[i]),
      .mask_on    (output_mask_reg[i]),
      .idle_level (wave.idle_level[i]),
      .match      (wave.match[i]),
      .level      (wave.level[i]),
      .out_bit    (chan_out[i])
    );
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_init_reset:
  assert property (@(posedge clock)
    rst |=> (output_init_reg == `PWMOI_RST_BYTE))
  else
    $error("init register not cleared by reset");

  a_init_write:
  assert property (@(posedge clock) disable iff (rst)
    wr_init ##1 (reg_req.rd && reg_req.addr == `PWMOI_OFS_INIT && !wr_init)
    |=> (reg_rdata == $past(reg_req.wdata, 2)))
  else
    $error("init write not read back");

  a_init_drive:
  assert property (@(posedge clock) disable iff (rst)
    init_strobe |=> (chan_out == $past(output_init_reg)))
  else
    $error("outputs do not take init values");

  a_mask_reset:
  assert property (@(posedge clock)
    rst |=> (output_mask_reg == `PWMOI_RST_BYTE && mask_pending == `PWMOI_RST_BYTE))
  else
    $error("mask not cleared by reset");

  a_mask_hold:
  assert property (@(posedge clock) disable iff (rst)
    !init_strobe |=>
      (((chan_out ^ $past(wave.idle_level)) & $past(output_mask_reg)) == '0))
  else
    $error("masked channel not at inactive level");

  a_unmask_pass:
  assert property (@(posedge clock) disable iff (rst)
    !init_strobe |=>
      (((chan_out ^ $past(wave.level))
        & $past(wave.match & ~output_mask_reg)) == '0))
  else
    $error("unmasked channel did not follow its waveform");

  a_unmask_idle:
  assert property (@(posedge clock) disable iff (rst)
    !init_strobe |=>
      (((chan_out ^ $past(chan_out))
        & $past(~wave.match & ~output_mask_reg)) == '0))
  else
    $error("unmasked channel changed without a match");

  a_mask_no_match:
  assert property (@(posedge clock) disable iff (rst)
    (!init_strobe && output_mask_reg == '1) ##1 (!init_strobe && output_mask_reg == '1)
    |=> $stable(chan_out) || (chan_out == $past(wave.idle_level)))
  else
    $error("fully masked outputs reacted to a match");

  a_write_buffered:
  assert property (@(posedge clock) disable iff (rst)
    (wr_mask && mask_sync_select_reg && !pwm_sync && !wr_sync)
    |=> (mask_pending == $past(reg_req.wdata))
        && $stable(output_mask_reg))
  else
    $error("mask write reached active mask directly");

  a_sync_xfer:
  assert property (@(posedge clock) disable iff (rst)
    (mask_sync_select_reg && pwm_sync) |=> (output_mask_reg == $past(mask_pending)))
  else
    $error("sync event did not move mask buffer");

  a_free_xfer:
  assert property (@(posedge clock) disable iff (rst)
    (wr_mask && !mask_sync_select_reg) ##1 (!mask_sync_select_reg)
    |=> (output_mask_reg == $past(reg_req.wdata, 2)))
  else
    $error("mask not reloaded on every clock");

  a_wait_sync:
  assert property (@(posedge clock) disable iff (rst)
    (mask_sync_select_reg && !pwm_sync) |=> $stable(output_mask_reg))
  else
    $error("active mask changed without sync event");

  a_read_active:
  assert property (@(posedge clock) disable iff (rst)
    (reg_req.rd && reg_req.addr == `PWMOI_OFS_MASK)
    |=> (reg_rdata == $past(output_mask_reg)))
  else
    $error("mask read did not return active mask");

  a_init_load:
  assert property (@(posedge clock) disable iff (rst)
    wr_init |=> (output_init_reg == $past(reg_req.wdata)))
  else
    $error("init register did not take written value");

  a_init_hold:
  assert property (@(posedge clock) disable iff (rst)
    !wr_init |=> $stable(output_init_reg))
  else
    $error("init register changed without a write");

  a_read_init:
  assert property (@(posedge clock) disable iff (rst)
    (reg_req.rd && reg_req.addr == `PWMOI_OFS_INIT)
    |=> (reg_rdata == $past(output_init_reg)))
  else
    $error("init read did not return init register");

  a_mask_load:
  assert property (@(posedge clock) disable iff (rst)
    wr_mask |=> (mask_pending == $past(reg_req.wdata)))
  else
    $error("mask buffer did not take written value");

  a_buf_hold:
  assert property (@(posedge clock) disable iff (rst)
    !wr_mask |=> $stable(mask_pending))
  else
    $error("mask buffer changed without a write");

  a_sel_write:
  assert property (@(posedge clock) disable iff (rst)
    wr_sync |=> (mask_sync_select_reg == $past(reg_req.wdata[`PWMOI_SYNC_SEL_BIT])))
  else
    $error("sync select did not take written bit");

  a_sel_hold:
  assert property (@(posedge clock) disable iff (rst)
    !wr_sync |=> $stable(mask_sync_select_reg))
  else
    $error("sync select changed without a write");

  a_free_reload:
  assert property (@(posedge clock) disable iff (rst)
    !mask_sync_select_reg |=> (output_mask_reg == $past(mask_pending)))
  else
    $error("active mask not reloaded from buffer");

  a_read_sync:
  assert property (@(posedge clock) disable iff (rst)
    (reg_req.rd && reg_req.addr == `PWMOI_OFS_SYNC)
    |=> (reg_rdata == (8'($past(mask_sync_select_reg)) << `PWMOI_SYNC_SEL_BIT)))
  else
    $error("sync select read back wrong");

  a_read_other:
  assert property (@(posedge clock) disable iff (rst)
    (reg_req.rd && reg_req.addr != `PWMOI_OFS_INIT && reg_req.addr != `PWMOI_OFS_MASK
     && reg_req.addr != `PWMOI_OFS_SYNC)
    |=> (reg_rdata == `PWMOI_RST_BYTE))
  else
    $error("unmapped read returned data");

  a_out_reset:
  assert property (@(posedge clock)
    rst |=> (chan_out == `PWMOI_RST_BYTE && reg_rdata == `PWMOI_RST_BYTE))
  else
    $error("outputs not cleared by reset");

  a_rdata_idle:
  assert property (@(posedge clock) disable iff (rst)
    !reg_req.rd |=> (reg_rdata == `PWMOI_RST_BYTE))
  else
    $error("read data present without read strobe");

endmodule

/* dv/pwmoi_switch_model.sv */
`timescale 1ns/1ps
`include "pwmoi_cfg.svh"

// ----------------------------------------------------------------------
// Power switch bank driven by the channel outputs
// ----------------------------------------------------------------------
module pwmoi_switch_model
  import pwmoi_pkg::*;
(
  // Gate drive
  input  wire logic [`PWMOI_NCH-1:0] gate,
  // Switch state
  output logic      [`PWMOI_NCH-1:0] sw_on
);
  // Ideal switches, no turn-on delay, so checks need no extra latency
  assign sw_on = gate;
endmodule

/* dv/pwmoi_top_bench.sv */
`timescale 1ns/1ps
`include "pwmoi_cfg.svh"

module pwmoi_top_bench;
  import pwmoi_pkg::*;

  // --------------------------------------------------------------------
  // Stimulus and observation
  // --------------------------------------------------------------------
  logic                  clock       = 1'b0;
  logic                  rst         = 1'b1;
  pwmoi_req_s            reg_req     = '0;
  logic [7:0]            reg_rdata;
  logic                  init_strobe = 1'b0;
  logic                  pwm_sync    = 1'b0;
  pwmoi_wave_s           wave        = '0;
  logic [`PWMOI_NCH-1:0] chan_out;
  logic [`PWMOI_NCH-1:0] sw_on;
  int                    miscompares     = 0;
  int                    samples_checked = 0;
  int                    cycles          = 0;

  always #2 clock = ~clock;

  pwmoi_top DUT (
    .clock       (clock),
    .rst         (rst),
    .reg_req     (reg_req),
    .reg_rdata   (reg_rdata),
    .init_strobe (init_strobe),
    .pwm_sync    (pwm_sync),
    .wave        (wave),
    .chan_out    (chan_out)
  );

  pwmoi_switch_model switches (
    .gate  (chan_out),
    .sw_on (sw_on)
  );

  // --------------------------------------------------------------------
  // Access and compare tasks
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge clock);
    reg_req.wr    <= 1'b0;
  endtask

  // Write then read back with no idle cycle between the strobes
  task automatic reg_wr_rd(input string what, input logic [7:0] a, input logic [7:0] d);
    reg_wr(a, d);
    reg_req.rd <= 1'b1;
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1;
    chk(what, d, reg_rdata);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge clock);
    reg_req.rd   <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic out_chk(input int n, input logic [7:0] exp);
    repeat (n) @(posedge clock);
    #1;
    chk("sw_on", exp, sw_on);
  endtask

  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Hang guard, the tests need well under 200 cycles
  // --------------------------------------------------------------------
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      final_report();
    end
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    reg_rd("init", `PWMOI_OFS_INIT, 8'h00);
    reg_rd("mask", `PWMOI_OFS_MASK, 8'h00);
    reg_rd("sel", `PWMOI_OFS_SYNC, 8'h00);
    reg_wr(8'h1E, 8'hFF);
    reg_rd("unmapped", 8'h1E, 8'h00);
    reg_wr(`PWMOI_OFS_INIT, 8'h5A);
    reg_rd("init", `PWMOI_OFS_INIT, 8'h5A);
    reg_wr_rd("init", `PWMOI_OFS_INIT, 8'hA5);
    @(posedge clock);
    init_strobe     <= 1'b1;
    wave.idle_level <= 8'h0F;
    @(posedge clock);
    init_strobe <= 1'b0;
    #1;
    chk("init_out", 8'hA5, sw_on);
    // Select zero: mask lands two edges after the write
    reg_wr(`PWMOI_OFS_MASK, 8'h3C);
    out_chk(2, 8'h8D);
    reg_rd("mask", `PWMOI_OFS_MASK, 8'h3C);
    @(posedge clock);
    wave.match <= 8'hFF;
    wave.level <= 8'h55;
    @(posedge clock);
    wave.match <= 8'h00;
    #1;
    chk("match_out", 8'h4D, sw_on);
    // Select one: buffer waits for the sync pulse
    reg_wr(`PWMOI_OFS_SYNC, 8'hFF);
    reg_rd("sel", `PWMOI_OFS_SYNC, 8'h01);
    reg_wr(`PWMOI_OFS_MASK, 8'hFF);
    out_chk(4, 8'h4D);
    reg_rd("mask", `PWMOI_OFS_MASK, 8'h3C);
    @(posedge clock);
    pwm_sync <= 1'b1;
    @(posedge clock);
    pwm_sync <= 1'b0;
    out_chk(1, 8'h0F);
    reg_rd("mask", `PWMOI_OFS_MASK, 8'hFF);
    @(posedge clock);
    wave.match <= 8'hFF;
    wave.level <= 8'hF0;
    @(posedge clock);
    wave.match <= 8'h00;
    #1;
    chk("masked_match", 8'h0F, sw_on);
    out_chk(1, 8'h0F);
    final_report();
  end
endmodule
